// ### core/cos_shutdown_ctrl.sv
// Complementary output shutdown control with buffered delay counts.
//
// Summary of operation
// - Delays last Count to Count plus one periods.
// - Writing force flag enters shutdown at once.
// - Shutdown holds until rising event after clear.
// - Enabled fault forces override levels without software.
// - Four fault sources, each enabled, active low.
// - Faults are levels; shutdown holds while active.
// - Two override fields, A/C and B/D pairs.
// - Polarity only applies to inactive override.
// - Flag stays set while a fault persists.
// - Auto-restart clears flag, resumes on rising event.
// - Disabled: count writes reach buffers directly.
// - Enabled: load bit moves all counts together.
// - Hardware clears load bit after transfer.
// - Pin input serves as event or fault.
// - Fast oscillator kept running when selected.
// - Bit 7 enables module; bit 5 reads zero.
// - Bits 4-3 choose the generator clock.
// - Bits 2-0 choose the output mode.
//
// Chosen here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "cos_consts.svh"

// Counts generator ticks after a start pulse.
module cos_delay
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Control
    input wire logic start,
    input wire logic tick,
    input wire logic [7:0] count,
    // Status
    output logic busy,
    output logic done
);
    logic [8:0] left_r;

    // The first tick may come at once after the start, so one
    // extra tick is counted to guarantee the least time.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            busy <= 1'b0;
            left_r <= 9'h000;
        end
        else if (start && count != 8'h00)
        begin
            busy <= 1'b1;
            left_r <= {1'b0, count} + 9'h001;
        end
        else if (busy && tick)
        begin
            left_r <= left_r - 9'h001;
            busy <= (left_r != 9'h001);
        end
    end

    // A zero count passes the event straight through.
    assign done = (start && count == 8'h00) ||
        (busy && tick && left_r == 9'h001);
endmodule

module cos_shutdown_ctrl
    import cos_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port
    input wire cos_bus_req_t bus,
    output logic [7:0] rdata,
    // Fast oscillator tick and keep-alive request
    input wire logic fast_osc_tick,
    output logic fast_osc_keep,
    // Selected rising and falling event sources
    input wire logic rise_src_in,
    input wire logic fall_src_in,
    // Asynchronous pin, comparator and logic cell inputs
    input wire logic pin_in,
    input wire logic cmp1_in,
    input wire logic cmp2_in,
    input wire logic lc2_in,
    // Output drive, A to D in bits 0 to 3
    output logic [3:0] out_level,
    output logic [3:0] out_en,
    output logic [2:0] output_mode_select,
    output logic shutdown_active
);
    logic module_on_bit_r;
    logic count_buffer_load_r;
    cos_clk_sel_t clk_sel_r;
    logic [2:0] mode_r;
    logic [1:0] dbs_r;
    logic [3:0] pol_r;
    logic shutdown_force_flag_r;
    logic auto_restart_select_r;
    cos_ovr_t ovr_ac_r;
    cos_ovr_t ovr_bd_r;
    logic [3:0] src_en_r;
    logic [1:0] evsel_r;
    logic [7:0] cnt_reg_r [`COS_CNT_NUM];
    logic [7:0] cnt_buf_r [`COS_CNT_NUM];
    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] src_r;
    logic [1:0] div_r;
    logic gen_tick;
    logic fault;
    logic rise_lvl;
    logic fall_lvl;
    logic rise_q_r;
    logic fall_q_r;
    logic rise_edge;
    logic fall_edge;
    logic rise_ev;
    logic fall_ev;
    logic blk_r_busy;
    logic blk_f_busy;
    logic db_r_done;
    logic db_f_done;
    logic prim_on_r;
    logic comp_on_r;
    cos_state_t st_r;
    logic wr_asd0;
    logic cnt_wr;
    logic [2:0] cnt_idx;
    logic [3:0] lvl_nxt;
    logic [3:0] en_nxt;

    // Fault inputs are asynchronous: three stages, and a level is
    // taken only once the last two stages agree. Stages reset high,
    // the idle level, so no false fault or edge follows reset.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            s1_r <= 4'hF;
            s2_r <= 4'hF;
            s3_r <= 4'hF;
            src_r <= 4'hF;
        end
        else
        begin
            s1_r <= {lc2_in, cmp1_in, cmp2_in, pin_in};
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < 4; i++)
            begin
                if (s2_r[i] == s3_r[i])
                begin
                    src_r[i] <= s3_r[i];
                end
            end
        end
    end

    // An enabled source asks for shutdown while it is low.
    assign fault = |(src_en_r & ~src_r);

    // Generator clock as an enable pulse from the selected source.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            div_r <= 2'h0;
        end
        else
        begin
            div_r <= div_r + 2'h1;
        end
    end

    always_comb
    begin
        gen_tick = 1'b0;
        unique case (clk_sel_r)
            CLK_DIV4: gen_tick = (div_r == `COS_DIV4_LAST);
            CLK_SYS: gen_tick = 1'b1;
            CLK_FAST: gen_tick = fast_osc_tick;
            CLK_RSVD: gen_tick = 1'b0;
        endcase
        gen_tick = gen_tick & module_on_bit_r;
    end

    assign fast_osc_keep = module_on_bit_r &&
        clk_sel_r == CLK_FAST;

    // Event edges; the pin may feed either event.
    assign rise_lvl = rise_src_in | (evsel_r[0] & src_r[0]);
    assign fall_lvl = fall_src_in | (evsel_r[1] & src_r[0]);

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rise_q_r <= 1'b0;
            fall_q_r <= 1'b0;
        end
        else
        begin
            rise_q_r <= rise_lvl;
            fall_q_r <= fall_lvl;
        end
    end

    // Each blanking counter masks the opposite event.
    assign rise_edge = module_on_bit_r && rise_lvl && !rise_q_r &&
        !blk_f_busy;
    assign fall_edge = module_on_bit_r && fall_lvl && !fall_q_r &&
        !blk_r_busy;

    cos_delay u_ph_r (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(rise_edge),
        .tick(gen_tick),
        .count(cnt_buf_r[0]),
        .busy(),
        .done(rise_ev)
    );

    cos_delay u_ph_f (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(fall_edge),
        .tick(gen_tick),
        .count(cnt_buf_r[1]),
        .busy(),
        .done(fall_ev)
    );

    cos_delay u_db_r (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(rise_ev),
        .tick(gen_tick),
        .count(cnt_buf_r[2]),
        .busy(),
        .done(db_r_done)
    );

    cos_delay u_db_f (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(fall_ev),
        .tick(gen_tick),
        .count(cnt_buf_r[3]),
        .busy(),
        .done(db_f_done)
    );

    cos_delay u_blk_r (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(rise_ev),
        .tick(gen_tick),
        .count(cnt_buf_r[4]),
        .busy(blk_r_busy),
        .done()
    );

    cos_delay u_blk_f (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .start(fall_ev),
        .tick(gen_tick),
        .count(cnt_buf_r[5]),
        .busy(blk_f_busy),
        .done()
    );

    // Drive latches; a fault resets them at once.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst || fault || !module_on_bit_r)
        begin
            prim_on_r <= 1'b0;
            comp_on_r <= 1'b0;
        end
        else
        begin
            if (rise_ev)
            begin
                comp_on_r <= 1'b0;
            end
            else if (fall_ev)
            begin
                prim_on_r <= 1'b0;
            end
            if (db_r_done && !fall_ev)
            begin
                prim_on_r <= 1'b1;
            end
            if (db_f_done && !rise_ev)
            begin
                comp_on_r <= 1'b1;
            end
        end
    end

    // Shutdown state leaves only on a rising event with the flag
    // clear and no enabled fault low.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            st_r <= ST_SHUT;
        end
        else if (shutdown_force_flag_r || fault)
        begin
            st_r <= ST_SHUT;
        end
        else if (st_r == ST_SHUT && rise_ev)
        begin
            st_r <= ST_RUN;
        end
    end

    assign shutdown_active = (st_r == ST_SHUT);

    assign wr_asd0 = bus.wr && bus.addr == `COS_OFS_ASD0;

    // Force flag: a fault or a software set wins over any clear.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            shutdown_force_flag_r <= 1'b0;
        end
        else if (fault || (wr_asd0 && bus.wdata[`COS_ASD0_ASE]))
        begin
            shutdown_force_flag_r <= 1'b1;
        end
        else if (wr_asd0)
        begin
            shutdown_force_flag_r <= 1'b0;
        end
        else if (auto_restart_select_r)
        begin
            shutdown_force_flag_r <= 1'b0;
        end
    end

    // Plain control registers.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            module_on_bit_r <= 1'b0;
            clk_sel_r <= CLK_DIV4;
            mode_r <= 3'h0;
            dbs_r <= 2'h0;
            pol_r <= 4'h0;
            auto_restart_select_r <= 1'b0;
            ovr_ac_r <= OVR_LOW;
            ovr_bd_r <= OVR_LOW;
            src_en_r <= 4'h0;
            evsel_r <= 2'h0;
        end
        else if (bus.wr)
        begin
            unique case (bus.addr)
                `COS_OFS_CON0:
                begin
                    module_on_bit_r <= bus.wdata[`COS_CON0_EN];
                    clk_sel_r <= cos_clk_sel_t'(bus.wdata[4:3]);
                    mode_r <= bus.wdata[2:0];
                end
                `COS_OFS_CON1:
                begin
                    dbs_r <= bus.wdata[7:6];
                    pol_r <= bus.wdata[3:0];
                end
                `COS_OFS_ASD0:
                begin
                    auto_restart_select_r <= bus.wdata[`COS_ASD0_ARS];
                    ovr_bd_r <= cos_ovr_t'(bus.wdata[3:2]);
                    ovr_ac_r <= cos_ovr_t'(bus.wdata[1:0]);
                end
                `COS_OFS_ASD1: src_en_r <= bus.wdata[3:0];
                `COS_OFS_EVSEL: evsel_r <= bus.wdata[1:0];
                default:
                begin
                end
            endcase
        end
    end

    assign output_mode_select = mode_r;

    // Count registers and their working buffers.
    assign cnt_wr = bus.wr && bus.addr >= `COS_OFS_PHR &&
        bus.addr <= `COS_OFS_BLKF;
    assign cnt_idx = 3'(bus.addr - `COS_OFS_PHR);

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < `COS_CNT_NUM; i++)
            begin
                cnt_reg_r[i] <= `COS_REG_RST;
                cnt_buf_r[i] <= `COS_REG_RST;
            end
        end
        else
        begin
            if (cnt_wr)
            begin
                cnt_reg_r[cnt_idx] <= bus.wdata;
            end
            if (!module_on_bit_r && cnt_wr)
            begin
                cnt_buf_r[cnt_idx] <= bus.wdata;
            end
            else if (module_on_bit_r && count_buffer_load_r &&
                (rise_edge || fall_edge))
            begin
                for (int i = 0; i < `COS_CNT_NUM; i++)
                begin
                    cnt_buf_r[i] <= cnt_reg_r[i];
                end
            end
        end
    end

    // Load bit: a software set wins over the hardware clear.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            count_buffer_load_r <= 1'b0;
        end
        else if (bus.wr && bus.addr == `COS_OFS_CON0 &&
            bus.wdata[`COS_CON0_LD])
        begin
            count_buffer_load_r <= 1'b1;
        end
        else if (module_on_bit_r && (rise_edge || fall_edge))
        begin
            count_buffer_load_r <= 1'b0;
        end
    end

    // Read data one cycle after the strobe; unmapped reads zero.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rdata <= 8'h00;
        end
        else if (bus.rd)
        begin
            rdata <= 8'h00;
            unique case (bus.addr)
                `COS_OFS_CON0:
                    rdata <= {module_on_bit_r, count_buffer_load_r,
                        1'b0, clk_sel_r, mode_r};
                `COS_OFS_CON1: rdata <= {dbs_r, 2'b00, pol_r};
                `COS_OFS_ASD0:
                    rdata <= {1'b0, shutdown_force_flag_r,
                        auto_restart_select_r, 1'b0, ovr_bd_r,
                        ovr_ac_r};
                `COS_OFS_ASD1: rdata <= {4'h0, src_en_r};
                `COS_OFS_EVSEL: rdata <= {6'h00, evsel_r};
                default:
                begin
                    if (bus.addr <= `COS_OFS_BLKF)
                    begin
                        rdata <= cnt_reg_r[cnt_idx];
                    end
                end
            endcase
        end
    end

    // Output levels: override codes ignore polarity except the
    // inactive choice, which is the idle level set by the polarity bit.
    always_comb
    begin
        cos_ovr_t ovr;
        logic act;
        ovr = OVR_LOW;
        act = 1'b0;
        lvl_nxt = 4'h0;
        en_nxt = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            ovr = (i % 2 == 0) ? ovr_ac_r : ovr_bd_r;
            act = (i % 2 == 0) ? prim_on_r : comp_on_r;
            if (!module_on_bit_r)
            begin
                lvl_nxt[i] = 1'b0;
                en_nxt[i] = 1'b0;
            end
            else if (st_r == ST_SHUT || fault)
            begin
                unique case (ovr)
                    OVR_LOW: lvl_nxt[i] = 1'b0;
                    OVR_HIGH: lvl_nxt[i] = 1'b1;
                    OVR_HIZ: lvl_nxt[i] = 1'b0;
                    OVR_IDLE: lvl_nxt[i] = pol_r[i];
                endcase
                en_nxt[i] = (ovr != OVR_HIZ);
            end
            else
            begin
                lvl_nxt[i] = act ^ pol_r[i];
                en_nxt[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            out_level <= 4'h0;
            out_en <= 4'h0;
        end
        else
        begin
            out_level <= lvl_nxt;
            out_en <= en_nxt;
        end
    end
endmodule

// ### core/cos_consts.svh
// Register offsets, field positions and reset values of the shutdown slice.
`ifndef COS_CONSTS_SVH
`define COS_CONSTS_SVH
`define COS_OFS_CON0 4'h0
`define COS_OFS_CON1 4'h1
`define COS_OFS_ASD0 4'h2
`define COS_OFS_ASD1 4'h3
`define COS_OFS_PHR 4'h4
`define COS_OFS_PHF 4'h5
`define COS_OFS_DBR 4'h6
`define COS_OFS_DBF 4'h7
`define COS_OFS_BLKR 4'h8
`define COS_OFS_BLKF 4'h9
`define COS_OFS_EVSEL 4'hA
`define COS_CON0_EN 7
`define COS_CON0_LD 6
`define COS_ASD0_ASE 6
`define COS_ASD0_ARS 5
`define COS_REG_RST 8'h00
`define COS_DIV4_LAST 2'h3
`define COS_CNT_NUM 6
`endif

// ### core/cos_pkg.sv
// Types shared by the shutdown slice.
package cos_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cos_bus_req_t;
    typedef enum logic [1:0] {
        OVR_LOW = 2'b00,
        OVR_HIGH = 2'b01,
        OVR_HIZ = 2'b10,
        OVR_IDLE = 2'b11
    } cos_ovr_t;
    typedef enum logic [1:0] {
        CLK_DIV4 = 2'b00,
        CLK_SYS = 2'b01,
        CLK_FAST = 2'b10,
        CLK_RSVD = 2'b11
    } cos_clk_sel_t;
    typedef enum logic [1:0] {
        ST_RUN = 2'b01,
        ST_SHUT = 2'b10
    } cos_state_t;
endpackage

// ### verif/cos_far_side.sv
// Event sources and fault lines that face the shutdown slice.
`timescale 1ns/1ps
module cos_far_side
(
    // Clock and commands from the bench
    input wire logic sys_clk,
    input wire logic fire,
    input wire logic [3:0] fault_n,
    // Event levels
    output logic rise_src_in,
    output logic fall_src_in,
    // Fault lines, low while a fault stands
    output logic pin_in,
    output logic cmp2_in,
    output logic cmp1_in,
    output logic lc2_in
);
    logic [3:0] phase_r = 4'h0;

    // Faults come from analog parts, so they move away from clock edges.
    assign #7 {lc2_in, cmp1_in, cmp2_in, pin_in} = fault_n;

    // One fire gives a four cycle rising pulse, then a falling one.
    always @(posedge sys_clk)
    begin
        if (fire)
            phase_r <= 4'h8;
        else if (phase_r != 4'h0)
            phase_r <= phase_r - 4'h1;
    end
    assign rise_src_in = phase_r > 4'h4;
    assign fall_src_in = phase_r inside {[4'h1:4'h4]};
endmodule

// ### verif/cos_shutdown_ctrl_asserts.sv
// Concurrent checks on the ports of the shutdown slice.
`timescale 1ns/1ps
`include "cos_consts.svh"
module cos_shutdown_ctrl_asserts
    import cos_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port
    input wire cos_bus_req_t bus,
    input wire logic [7:0] rdata,
    // Oscillator
    input wire logic fast_osc_tick,
    input wire logic fast_osc_keep,
    // Events and faults
    input wire logic rise_src_in,
    input wire logic fall_src_in,
    input wire logic pin_in,
    input wire logic cmp1_in,
    input wire logic cmp2_in,
    input wire logic lc2_in,
    // Outputs
    input wire logic [3:0] out_level,
    input wire logic [3:0] out_en,
    input wire logic [2:0] output_mode_select,
    input wire logic shutdown_active
);
    logic [7:0] con0_r, con1_r, asd0_r, asd1_r;
    logic [5:0] since_rise_r;
    logic rise_d_r;
    logic [3:0] fault_now, en_exp, lv_exp;
    logic [1:0] ov_a, ov_b, ov_c, ov_d;

    function automatic logic [1:0] ov(input logic [1:0] c, input logic p);
        case (c)
            2'b00: ov = 2'b10;
            2'b01: ov = 2'b11;
            2'b10: ov = 2'b00;
            default: ov = {1'b1, p};
        endcase
    endfunction

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    // The flag shadow is dropped once auto-restart may have cleared it.
    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            con0_r <= 8'h00;
            con1_r <= 8'h00;
            asd0_r <= 8'h00;
            asd1_r <= 8'h00;
        end
        else if (bus.wr)
        begin
            case (bus.addr)
                `COS_OFS_CON0: con0_r <= bus.wdata;
                `COS_OFS_CON1: con1_r <= bus.wdata;
                `COS_OFS_ASD0: asd0_r <= bus.wdata;
                `COS_OFS_ASD1: asd1_r <= bus.wdata;
                default: ;
            endcase
        end
        else if (asd0_r[5])
            asd0_r[6] <= 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!nrst)
        begin
            rise_d_r <= 1'b1;
            since_rise_r <= 6'h3F;
        end
        else
        begin
            rise_d_r <= rise_src_in;
            if (rise_src_in && !rise_d_r)
                since_rise_r <= 6'h00;
            else if (since_rise_r != 6'h3F)
                since_rise_r <= since_rise_r + 6'h01;
        end
    end

    assign fault_now = asd1_r[3:0] & ~{lc2_in, cmp1_in, cmp2_in, pin_in};
    assign ov_a = ov(asd0_r[1:0], con1_r[0]);
    assign ov_b = ov(asd0_r[3:2], con1_r[1]);
    assign ov_c = ov(asd0_r[1:0], con1_r[2]);
    assign ov_d = ov(asd0_r[3:2], con1_r[3]);
    assign en_exp = {ov_d[1], ov_c[1], ov_b[1], ov_a[1]};
    assign lv_exp = {ov_d[0], ov_c[0], ov_b[0], ov_a[0]};

    force_enter_a:
        assert property (bus.wr && bus.addr == `COS_OFS_ASD0 && bus.wdata[6]
            |-> ##[1:2] shutdown_active) else $error("force write ignored");
    fault_hold_a:
        assert property ((|fault_now) [*7] |-> shutdown_active)
        else $error("fault did not hold shutdown");
    ovr_pair_a:
        assert property (con0_r[7] && $past(con0_r[7]) && shutdown_active
            && $past(shutdown_active) && $stable(asd0_r[3:0])
            && $stable(con1_r[3:0]) |-> out_en == en_exp
            && (out_level & out_en) == lv_exp)
        else $error("override level wrong");
    con0_read_a:
        assert property (bus.rd && bus.addr == `COS_OFS_CON0 |=>
            rdata[5] == 1'b0 && rdata[7] == $past(con0_r[7])
            && rdata[4:0] == $past(con0_r[4:0]))
        else $error("control read wrong");
    mode_out_a:
        assert property (bus.wr && bus.addr == `COS_OFS_CON0 |=>
            output_mode_select == $past(bus.wdata[2:0]))
        else $error("mode output wrong");
    keep_alive_a:
        assert property (fast_osc_keep == (con0_r[7] && con0_r[4:3] == 2'b10))
        else $error("fast oscillator request wrong");
    exit_event_a:
        assert property ($fell(shutdown_active) |->
            con0_r[7] && since_rise_r < 6'h14)
        else $error("shutdown left without rising event");
    hold_flag_a:
        assert property (asd0_r[6] && $past(asd0_r[6], 2) |-> shutdown_active)
        else $error("shutdown left with flag set");

    cover property (bus.wr && bus.addr == `COS_OFS_ASD0 && bus.wdata[6]);
    cover property ($fell(shutdown_active));
    cover property (|fault_now);
endmodule

bind cos_shutdown_ctrl cos_shutdown_ctrl_asserts chk (
    .sys_clk(sys_clk), .nrst(nrst), .bus(bus), .rdata(rdata),
    .fast_osc_tick(fast_osc_tick), .fast_osc_keep(fast_osc_keep),
    .rise_src_in(rise_src_in), .fall_src_in(fall_src_in),
    .pin_in(pin_in), .cmp1_in(cmp1_in), .cmp2_in(cmp2_in),
    .lc2_in(lc2_in), .out_level(out_level), .out_en(out_en),
    .output_mode_select(output_mode_select),
    .shutdown_active(shutdown_active));

// ### verif/test_cos_shutdown_ctrl.sv
// Self-checking bench of the shutdown control slice.
`timescale 1ns/1ps
`include "cos_consts.svh"
`define check_eq(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module test_cos_shutdown_ctrl
    import cos_pkg::*;
    ;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    cos_bus_req_t bus = '0;
    logic [7:0] rdata, pol, exp_v;
    logic fast_osc_tick = 1'b0;
    logic fast_osc_keep, rise_src_in, fall_src_in, shutdown_active;
    logic pin_in, cmp1_in, cmp2_in, lc2_in;
    logic [3:0] out_level, out_en;
    logic [3:0] fault_n = 4'hF;
    logic [2:0] output_mode_select;
    logic [1:0] oa, ob, pa, pb;
    logic fire = 1'b0;
    logic rd_d = 1'b0;
    logic [7:0] exp_q[$];
    int errors = 0;
    int n_checks = 0;
    int seed = 32'h068a_bb19;
    int d0, d4, d;

    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) fast_osc_tick <= ~fast_osc_tick;
    assign pa = {out_en[0], out_level[0] & out_en[0]};
    assign pb = {out_en[1], out_level[1] & out_en[1]};

    cos_shutdown_ctrl dut (.sys_clk(sys_clk), .nrst(nrst), .bus(bus),
        .rdata(rdata), .fast_osc_tick(fast_osc_tick),
        .fast_osc_keep(fast_osc_keep), .rise_src_in(rise_src_in),
        .fall_src_in(fall_src_in), .pin_in(pin_in), .cmp1_in(cmp1_in),
        .cmp2_in(cmp2_in), .lc2_in(lc2_in), .out_level(out_level),
        .out_en(out_en), .output_mode_select(output_mode_select),
        .shutdown_active(shutdown_active));
    cos_far_side far (.sys_clk(sys_clk), .fire(fire), .fault_n(fault_n),
        .rise_src_in(rise_src_in), .fall_src_in(fall_src_in),
        .pin_in(pin_in), .cmp2_in(cmp2_in), .cmp1_in(cmp1_in),
        .lc2_in(lc2_in));

    function automatic logic [1:0] ov(input logic [1:0] c, input logic p);
        case (c)
            2'b00: ov = 2'b10;
            2'b01: ov = 2'b11;
            2'b10: ov = 2'b00;
            default: ov = {1'b1, p};
        endcase
    endfunction

    // Read data are checked in the cycle after the strobe.
    always @(posedge sys_clk) rd_d <= bus.rd;
    always @(negedge sys_clk)
    begin
        if (rd_d)
        begin
            exp_v = exp_q.pop_front();
            `check_eq(rdata, exp_v)
        end
    end

    task automatic report_and_stop();
        begin
            $display("checks %0d mismatches %0d", n_checks, errors);
            if (errors == 0 && n_checks > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        begin
            @(posedge sys_clk);
            bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
            @(posedge sys_clk);
            bus.wr <= 1'b0;
        end
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        begin
            @(posedge sys_clk);
            exp_q.push_back(e);
            bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
            @(posedge sys_clk);
            bus.rd <= 1'b0;
        end
    endtask

    task automatic wait_cyc(input int n);
        begin
            repeat (n) @(posedge sys_clk);
            @(negedge sys_clk);
        end
    endtask

    task automatic fire_ev();
        begin
            @(posedge sys_clk);
            fire <= 1'b1;
            @(posedge sys_clk);
            fire <= 1'b0;
        end
    endtask

    // Cycles from the fire command until shutdown is left.
    task automatic go_run(output int n);
        begin
            fire_ev();
            n = 0;
            while (shutdown_active !== 1'b0 && n < 40)
            begin
                @(negedge sys_clk);
                n++;
            end
            `check_eq(shutdown_active, 1'b0)
        end
    endtask

    initial
    begin
        #(25 * 20000);
        errors++;
        report_and_stop();
    end

    initial
    begin
        pol = 8'($random(seed));
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int a = 0; a < 12; a++)
            rd(4'(a), `COS_REG_RST);
        `check_eq(shutdown_active, 1'b1)
        $display("reset values done");
        for (int m = 0; m < 6; m++)
        begin
            wr(`COS_OFS_CON0, {3'b001, 2'(m % 3), 3'(m)});
            rd(`COS_OFS_CON0, {3'b000, 2'(m % 3), 3'(m)});
            `check_eq(output_mode_select, 3'(m))
        end
        wr(`COS_OFS_CON0, 8'h90);
        @(negedge sys_clk);
        `check_eq(fast_osc_keep, 1'b1)
        wr(`COS_OFS_CON0, 8'h00);
        $display("control fields done");
        wr(`COS_OFS_CON1, {4'h0, pol[3:0]});
        wr(`COS_OFS_ASD0, 8'h40);
        wr(`COS_OFS_CON0, 8'h88);
        for (int c = 0; c < 4; c++)
        begin
            wr(`COS_OFS_ASD0, {4'h4, 2'(3 - c), 2'(c)});
            wait_cyc(4);
            oa = ov(2'(c), pol[0]);
            ob = ov(2'(3 - c), pol[1]);
            `check_eq(pa, oa)
            `check_eq(pb, ob)
        end
        $display("override levels done");
        wr(`COS_OFS_ASD1, 8'h01);
        fault_n <= 4'hE;
        wait_cyc(8);
        wr(`COS_OFS_ASD0, 8'h03);
        rd(`COS_OFS_ASD0, 8'h43);
        fire_ev();
        wait_cyc(12);
        `check_eq(shutdown_active, 1'b1)
        fault_n <= 4'hF;
        wait_cyc(8);
        rd(`COS_OFS_ASD0, 8'h43);
        wr(`COS_OFS_ASD0, 8'h03);
        wait_cyc(10);
        `check_eq(shutdown_active, 1'b1)
        go_run(d0);
        $display("software restart done");
        for (int i = 0; i < 4; i++)
        begin
            wr(`COS_OFS_ASD1, 8'(1 << i));
            fault_n <= ~4'(1 << ((i + 1) % 4));
            wait_cyc(10);
            `check_eq(shutdown_active, 1'b0)
            fault_n <= ~4'(1 << i);
            wait_cyc(8);
            `check_eq(shutdown_active, 1'b1)
            wr(`COS_OFS_ASD0, 8'h23);
            fault_n <= 4'hF;
            wait_cyc(10);
            rd(`COS_OFS_ASD0, 8'h23);
            `check_eq(shutdown_active, 1'b1)
            go_run(d);
            wr(`COS_OFS_ASD0, 8'h03);
        end
        $display("fault sources done");
        wr(`COS_OFS_ASD0, 8'h43);
        wr(`COS_OFS_CON0, 8'h08);
        wr(`COS_OFS_PHR, 8'h04);
        wr(`COS_OFS_CON0, 8'h88);
        wr(`COS_OFS_ASD0, 8'h03);
        go_run(d4);
        `check_eq(d4 - d0 >= 4 && d4 - d0 <= 5, 1'b1)
        wr(`COS_OFS_PHR, 8'h00);
        wr(`COS_OFS_ASD0, 8'h43);
        wr(`COS_OFS_ASD0, 8'h03);
        go_run(d);
        `check_eq(d, d4)
        wr(`COS_OFS_CON0, 8'hC8);
        rd(`COS_OFS_CON0, 8'hC8);
        fire_ev();
        wait_cyc(12);
        rd(`COS_OFS_CON0, 8'h88);
        wr(`COS_OFS_ASD0, 8'h43);
        wr(`COS_OFS_ASD0, 8'h03);
        go_run(d);
        `check_eq(d, d0)
        $display("buffer load done");
        report_and_stop();
    end
endmodule
